// ### logic/b4sc_pkg.sv
/*
  Shared constants and types for the fourth buck converter's
  sequence configuration block.
  Assumes word-aligned APB access and register indices times four.
*/
package b4sc_pkg;
  localparam int ADDR_W = 18;
  // Register indices; byte address is index times four
  localparam logic [15:0] IDX_ACTIVE = 16'h4066;
  localparam logic [15:0] IDX_SLEEP = 16'h4067;
  localparam logic [15:0] IDX_HWCTL = 16'h4080;
  localparam logic [ADDR_W-1:0] ADR_ACTIVE = {IDX_ACTIVE, 2'h0};
  localparam logic [ADDR_W-1:0] ADR_SLEEP = {IDX_SLEEP, 2'h0};
  localparam logic [ADDR_W-1:0] ADR_HWCTL = {IDX_HWCTL, 2'h0};
  // Field positions
  localparam int SLOT_LSB = 13;
  localparam int MODE_LSB = 8;
  localparam int VHI_LSB = 2;
  localparam int HWSEL_BIT = 10;
  localparam int STATE_LSB = 0;
  localparam int ENABLE_BIT = 2;
  // Reset values
  localparam logic [2:0] RST_ACT_SLOT = 3'h0;
  localparam logic [1:0] RST_ACT_MODE = 2'h1;
  localparam logic [4:0] RST_ACT_VHI = 5'h00;
  localparam logic [1:0] RST_ACT_VLO = 2'h0;
  localparam logic [2:0] RST_SLP_SLOT = 3'h0;
  localparam logic [1:0] RST_SLP_MODE = 2'h3;
  localparam logic [6:0] RST_SLP_V = 7'h00;
  localparam logic RST_HWSEL = 1'h0;
  // Slot codes
  localparam logic [2:0] SLOT_NONE = 3'h0;
  localparam logic [2:0] SLOT_LAST = 3'h5;
  localparam logic [2:0] SLOT_HW2 = 3'h7;
  localparam logic [2:0] SLP_AT_T5 = 3'h5;
  localparam logic [2:0] SLP_CODE_T3 = 3'h6;
  localparam logic [2:0] SLP_CODE_T1 = 3'h7;
  localparam logic [2:0] SLP_AT_T3 = 3'h3;
  localparam logic [2:0] SLP_AT_T1 = 3'h1;
  localparam int SLP_DIS_BASE = 6;
  // Voltage map
  localparam int VMIN_MV = 850;
  localparam int VSTEP_MV = 25;
  localparam logic [6:0] VSAT_CODE = 7'h66;

  typedef enum logic [1:0] {B4SC_OFF, B4SC_ON, B4SC_SLEEP} b4sc_state_e;

  typedef struct packed {
    logic seq_en;
    logic [2:0] slot;
    logic hw;
    logic hw_sel2;
  } b4sc_act_s;

  typedef struct packed {
    logic [2:0] slot;
    logic disable_at;
  } b4sc_slp_s;

  typedef struct packed {
    logic enable;
    logic [1:0] mode;
    logic [6:0] vcode;
    logic [11:0] mv;
  } b4sc_drive_s;
endpackage : b4sc_pkg

// ### logic/b4sc_slot_decode.sv
/*
  Decodes the active and sleep slot fields into sequencer actions.
  Pure combinational; the caller registers whatever it needs.
*/
`timescale 1ns/1ps
`default_nettype none
module b4sc_slot_decode (
  input wire logic [2:0] active_slot,
  input wire logic [2:0] sleep_slot,
  output b4sc_pkg::b4sc_act_s act,
  output b4sc_pkg::b4sc_slp_s slp
);
  // Active slot: none, timeslot 1..5, or a hardware enable input
  always_comb begin
    act.seq_en = (active_slot != b4sc_pkg::SLOT_NONE) &&
                 (active_slot <= b4sc_pkg::SLOT_LAST);
    act.slot = active_slot;
    act.hw = active_slot > b4sc_pkg::SLOT_LAST;
    act.hw_sel2 = active_slot == b4sc_pkg::SLOT_HW2;
  end

  // Sleep slot: reverse order disable codes, else sleep transition
  always_comb begin
    slp.disable_at = 1'b0;
    unique case (sleep_slot)
      b4sc_pkg::SLOT_NONE: slp.slot = b4sc_pkg::SLP_AT_T5;
      b4sc_pkg::SLP_CODE_T3: slp.slot = b4sc_pkg::SLP_AT_T3;
      b4sc_pkg::SLP_CODE_T1: slp.slot = b4sc_pkg::SLP_AT_T1;
      default: begin
        // Codes 1..5 map to timeslots 5..1
        slp.slot = 3'(b4sc_pkg::SLP_DIS_BASE - int'(sleep_slot));
        slp.disable_at = 1'b1;
      end
    endcase
  end
endmodule : b4sc_slot_decode
`default_nettype wire

// ### logic/b4sc_vcode.sv
/*
  Maps a 7-bit voltage code to millivolts with top-end saturation.
  Combinational; no clock needed.
*/
`timescale 1ns/1ps
`default_nettype none
module b4sc_vcode (
  input wire logic [6:0] code,
  output logic [11:0] mv
);
  logic [6:0] sat;

  // Codes at and above the ceiling all give the maximum voltage
  always_comb begin
    sat = (code >= b4sc_pkg::VSAT_CODE) ? b4sc_pkg::VSAT_CODE : code;
    mv = 12'(b4sc_pkg::VMIN_MV + b4sc_pkg::VSTEP_MV * int'(sat));
  end
endmodule : b4sc_vcode
`default_nettype wire

// ### logic/b4sc_top.sv
/*
  Fourth buck converter sequence configuration: APB register file,
  on/sleep/off state machine and registered converter drive.
  Assumes slot_tick pulses once per timeslot from the power sequencer
  and that hardware enable inputs are synchronous to pclk.
*/
// Function
// - Active slot: off, timeslot, or hardware enable
// - Active mode field, four modes, reset auto
// - Voltage code 0.85V plus 25mV, saturating
// - Boot load sets upper five code bits
// - Active voltage code resets to zero
// - Sleep slot: sleep or disable per timeslot
// - Hardware enabled: disable codes mean sleep
// - Sleep mode field, reset hysteretic
// - Sleep voltage code, same map, reset zero
// - Hardware control picks active or sleep code
`timescale 1ns/1ps
`default_nettype none
module b4sc_top #(
  parameter int ADDR_W = b4sc_pkg::ADDR_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic slot_tick,
  input wire logic [2:0] slot_num,
  input wire logic slot_down,
  input wire logic hw_enable1,
  input wire logic hw_enable2,
  input wire logic boot_load,
  input wire logic [4:0] boot_vcode_hi,
  output b4sc_pkg::b4sc_drive_s drive
);
  logic [2:0] act_slot, next_act_slot;
  logic [1:0] act_mode, next_act_mode;
  logic [4:0] act_vhi, next_act_vhi;
  logic [1:0] act_vlo, next_act_vlo;
  logic [2:0] slp_slot, next_slp_slot;
  logic [1:0] slp_mode, next_slp_mode;
  logic [6:0] slp_v, next_slp_v;
  logic hw_choice, next_hw_choice;
  b4sc_pkg::b4sc_state_e state, next_state;
  b4sc_pkg::b4sc_drive_s next_drive;
  b4sc_pkg::b4sc_act_s act_dec;
  b4sc_pkg::b4sc_slp_s slp_dec;
  logic [31:0] next_prdata;
  logic [31:0] rd_word;
  logic [6:0] sel_code;
  logic [11:0] sel_mv;
  logic hit_act, hit_slp, hit_hw, mapped, wr, hw_in;
  logic tick_up, tick_dn;

  b4sc_slot_decode u_dec (
    .active_slot(act_slot),
    .sleep_slot(slp_slot),
    .act(act_dec),
    .slp(slp_dec)
  );

  b4sc_vcode u_vmap (
    .code(sel_code),
    .mv(sel_mv)
  );

  // Address decode; zero wait states, so pready is constant
  assign hit_act = paddr == b4sc_pkg::ADR_ACTIVE;
  assign hit_slp = paddr == b4sc_pkg::ADR_SLEEP;
  assign hit_hw = paddr == b4sc_pkg::ADR_HWCTL;
  assign mapped = hit_act | hit_slp | hit_hw;
  assign wr = psel & penable & pwrite & mapped;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped; // Unmapped answers error

  // Register next values; boot load beats a bus write in one cycle
  always_comb begin
    next_act_slot = act_slot;
    next_act_mode = act_mode;
    next_act_vhi = act_vhi;
    next_act_vlo = act_vlo;
    next_slp_slot = slp_slot;
    next_slp_mode = slp_mode;
    next_slp_v = slp_v;
    next_hw_choice = hw_choice;
    // Only field bits are taken; the rest are dropped
    if (wr && hit_act) begin
      next_act_slot = pwdata[b4sc_pkg::SLOT_LSB +: 3];
      next_act_mode = pwdata[b4sc_pkg::MODE_LSB +: 2];
      next_act_vhi = pwdata[b4sc_pkg::VHI_LSB +: 5];
      next_act_vlo = pwdata[b4sc_pkg::VHI_LSB-1:0];
    end
    if (wr && hit_slp) begin
      next_slp_slot = pwdata[b4sc_pkg::SLOT_LSB +: 3];
      next_slp_mode = pwdata[b4sc_pkg::MODE_LSB +: 2];
      next_slp_v = pwdata[6:0];
    end
    if (wr && hit_hw) begin
      next_hw_choice = pwdata[b4sc_pkg::HWSEL_BIT];
    end
    // Nonvolatile copy holds only the coarse 100mV bits
    if (boot_load) begin
      next_act_vhi = boot_vcode_hi;
      next_act_vlo = b4sc_pkg::RST_ACT_VLO;
    end
  end

  // Register file storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_slot <= b4sc_pkg::RST_ACT_SLOT;
      act_mode <= b4sc_pkg::RST_ACT_MODE;
      act_vhi <= b4sc_pkg::RST_ACT_VHI;
      act_vlo <= b4sc_pkg::RST_ACT_VLO;
      slp_slot <= b4sc_pkg::RST_SLP_SLOT;
      slp_mode <= b4sc_pkg::RST_SLP_MODE;
      slp_v <= b4sc_pkg::RST_SLP_V;
      hw_choice <= b4sc_pkg::RST_HWSEL;
    end else begin
      act_slot <= next_act_slot;
      act_mode <= next_act_mode;
      act_vhi <= next_act_vhi;
      act_vlo <= next_act_vlo;
      slp_slot <= next_slp_slot;
      slp_mode <= next_slp_mode;
      slp_v <= next_slp_v;
      hw_choice <= next_hw_choice;
    end
  end

  assign hw_in = act_dec.hw_sel2 ? hw_enable2 : hw_enable1;
  assign tick_up = slot_tick & ~slot_down;
  assign tick_dn = slot_tick & slot_down;

  // Converter state; hardware input overrides the slot sequence
  always_comb begin
    next_state = state;
    if (act_dec.hw) begin
      if (!hw_in) begin
        next_state = b4sc_pkg::B4SC_OFF;
      end else if (state == b4sc_pkg::B4SC_OFF || tick_up) begin
        next_state = b4sc_pkg::B4SC_ON;
      end else if (tick_dn && slot_num == slp_dec.slot) begin
        next_state = b4sc_pkg::B4SC_SLEEP;
      end
    end else if (!act_dec.seq_en) begin
      next_state = b4sc_pkg::B4SC_OFF;
    end else if (tick_up && slot_num == act_dec.slot) begin
      next_state = b4sc_pkg::B4SC_ON;
    end else if (tick_dn && slot_num == slp_dec.slot &&
                 state != b4sc_pkg::B4SC_OFF) begin
      next_state = slp_dec.disable_at ? b4sc_pkg::B4SC_OFF
                                      : b4sc_pkg::B4SC_SLEEP;
    end
  end

  // Drive selection follows the state being entered
  always_comb begin
    sel_code = {act_vhi, act_vlo};
    next_drive.mode = act_mode;
    if (next_state == b4sc_pkg::B4SC_SLEEP) begin
      sel_code = slp_v;
      next_drive.mode = slp_mode;
    end else if (act_dec.hw && hw_choice) begin
      sel_code = slp_v;
    end
    next_drive.enable = next_state != b4sc_pkg::B4SC_OFF;
    next_drive.vcode = sel_code;
    next_drive.mv = sel_mv;
  end

  // Registered drive keeps the analog side glitch free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= b4sc_pkg::B4SC_OFF;
      drive <= '{enable: 1'b0, mode: b4sc_pkg::RST_ACT_MODE,
                 vcode: {b4sc_pkg::RST_ACT_VHI, b4sc_pkg::RST_ACT_VLO},
                 mv: 12'(b4sc_pkg::VMIN_MV)};
    end else begin
      state <= next_state;
      drive <= next_drive;
    end
  end

  // Read word; unassigned bits stay zero
  always_comb begin
    rd_word = 32'h0000_0000;
    if (hit_act) begin
      rd_word[b4sc_pkg::SLOT_LSB +: 3] = act_slot;
      rd_word[b4sc_pkg::MODE_LSB +: 2] = act_mode;
      rd_word[6:0] = {act_vhi, act_vlo};
    end else if (hit_slp) begin
      rd_word[b4sc_pkg::SLOT_LSB +: 3] = slp_slot;
      rd_word[b4sc_pkg::MODE_LSB +: 2] = slp_mode;
      rd_word[6:0] = slp_v;
    end else if (hit_hw) begin
      rd_word[b4sc_pkg::HWSEL_BIT] = hw_choice;
      rd_word[b4sc_pkg::STATE_LSB +: 2] = state;
      rd_word[b4sc_pkg::ENABLE_BIT] = drive.enable;
    end
    // Captured in setup so data is a flop output during access
    next_prdata = prdata;
    if (psel && !penable && !pwrite) begin
      next_prdata = rd_word;
    end
  end

  // Read data register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= next_prdata;
    end
  end

  // Helper: high only in the first cycle after reset release
  logic fresh;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fresh <= 1'b1;
    end else begin
      fresh <= 1'b0;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_slot_zero_off;
    act_slot == b4sc_pkg::SLOT_NONE |=> !drive.enable;
  endproperty
  a_slot_zero_off: assert property (p_slot_zero_off)
    else $error("Converter enabled with no active slot");

  property p_seq_on;
    tick_up && act_dec.seq_en && slot_num == act_slot
      |=> drive.enable && state == b4sc_pkg::B4SC_ON;
  endproperty
  a_seq_on: assert property (p_seq_on)
    else $error("Converter not on in its timeslot");

  property p_act_mode;
    next_state == b4sc_pkg::B4SC_ON |=> drive.mode == $past(act_mode);
  endproperty
  a_act_mode: assert property (p_act_mode)
    else $error("Active mode not driven");

  property p_mv_map;
    drive.mv == 12'(b4sc_pkg::VMIN_MV + b4sc_pkg::VSTEP_MV *
      int'((drive.vcode >= 7'h66) ? 7'h66 : drive.vcode));
  endproperty
  a_mv_map: assert property (p_mv_map)
    else $error("Voltage map mismatch");

  property p_boot_load;
    boot_load |=> act_vhi == $past(boot_vcode_hi) && act_vlo == 2'h0;
  endproperty
  a_boot_load: assert property (p_boot_load)
    else $error("Boot load did not set coarse bits");

  property p_reset_vals;
    fresh |-> {act_vhi, act_vlo} == 7'h00 && slp_v == 7'h00;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("Voltage codes not zero after reset");

  property p_reset_modes;
    fresh |-> act_mode == 2'h1 && slp_mode == 2'h3;
  endproperty
  a_reset_modes: assert property (p_reset_modes)
    else $error("Mode fields wrong after reset");

  property p_seq_disable;
    tick_dn && !act_dec.hw && act_dec.seq_en && slp_dec.disable_at &&
      slot_num == 3'(6 - int'(slp_slot)) && !(tick_up)
      |=> !drive.enable;
  endproperty
  a_seq_disable: assert property (p_seq_disable)
    else $error("Converter not disabled in its timeslot");

  property p_hw_sleep;
    act_dec.hw && hw_in && tick_dn && state != b4sc_pkg::B4SC_OFF &&
      slot_num == slp_dec.slot |=> state == b4sc_pkg::B4SC_SLEEP;
  endproperty
  a_hw_sleep: assert property (p_hw_sleep)
    else $error("Hardware controlled converter missed sleep");

  property p_slp_drive;
    next_state == b4sc_pkg::B4SC_SLEEP
      |=> drive.mode == $past(slp_mode) && drive.vcode == $past(slp_v);
  endproperty
  a_slp_drive: assert property (p_slp_drive)
    else $error("Sleep settings not driven");

  property p_hw_vsel;
    next_state == b4sc_pkg::B4SC_ON && act_dec.hw && hw_choice
      |=> drive.vcode == $past(slp_v);
  endproperty
  a_hw_vsel: assert property (p_hw_vsel)
    else $error("Hardware voltage choice ignored");

  property p_rsvd_zero;
    psel && penable && !pwrite && hit_act |-> prdata[12:10] == 3'h0 &&
      prdata[31:16] == 16'h0000 && prdata[7] == 1'b0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("Unassigned bits read nonzero");

  property p_rsvd_slp;
    psel && penable && !pwrite && hit_slp |-> prdata[12:10] == 3'h0 &&
      prdata[31:16] == 16'h0000 && prdata[7] == 1'b0;
  endproperty
  a_rsvd_slp: assert property (p_rsvd_slp)
    else $error("Unassigned sleep bits read nonzero");

  property p_unmapped_read;
    psel && penable && !pwrite && !mapped
      |-> pslverr && prdata == 32'h0000_0000;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("Unmapped read not zero with error");

  // Hardware input low must hold the converter off, whatever the state
  property p_hw_off;
    act_dec.hw && !hw_in |=> !drive.enable;
  endproperty
  a_hw_off: assert property (p_hw_off)
    else $error("Converter on with hardware enable low");

  property p_hw_on;
    act_dec.hw && hw_in && state == b4sc_pkg::B4SC_OFF
      |=> drive.enable && state == b4sc_pkg::B4SC_ON;
  endproperty
  a_hw_on: assert property (p_hw_on)
    else $error("Converter not on with hardware enable high");

  c_seq_on: cover property (tick_up ##1 state == b4sc_pkg::B4SC_ON);
  c_sleep: cover property (state == b4sc_pkg::B4SC_SLEEP);
  c_hw_on: cover property (act_dec.hw && drive.enable);
  c_sat: cover property (drive.vcode > 7'h66 && drive.enable);
  c_hw_sleep: cover property (act_dec.hw && state == b4sc_pkg::B4SC_SLEEP);
endmodule : b4sc_top
`default_nettype wire

// ### verification/b4sc_bench.sv
/*
  Self-checking bench for b4sc_top: APB register checks, timeslot
  sequencing and hardware enable, against an integer model.
  Assumes drive settles within three cycles of any stimulus.
*/
`timescale 1ns/1ps
`default_nettype none
module b4sc_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic slot_tick, slot_down, hw_enable1, hw_enable2, boot_load;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] slot_num;
  logic [4:0] boot_vcode_hi;
  b4sc_pkg::b4sc_drive_s drive, exp;
  int error_cnt, comparisons, seed, st, hsel, sc, i, t;
  int a_sl, a_md, a_v, s_sl, s_md, s_v;

  b4sc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .slot_tick(slot_tick), .slot_num(slot_num),
    .slot_down(slot_down), .hw_enable1(hw_enable1),
    .hw_enable2(hw_enable2), .boot_load(boot_load),
    .boot_vcode_hi(boot_vcode_hi), .drive(drive));

  // 10 MHz clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task end_of_test;
    if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  task chk(input logic [31:0] got, input logic [31:0] want);
    comparisons++;
    if (got !== want) begin
      error_cnt++;
      $display("wrong value at %0t: word %h not %h", $time, got, want);
    end
  endtask : chk

  // Off state only pins enable; mode and code are don't-care then
  task chk_drv(input b4sc_pkg::b4sc_drive_s want);
    comparisons++;
    if (drive.enable !== want.enable || (want.enable && drive !== want)) begin
      error_cnt++;
      $display("wrong value at %0t: drive %h not %h", $time, drive, want);
    end
  endtask : chk_drv

  // One APB transfer; holds request until pready seen at an edge
  task apb(input logic wr, input logic [17:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function logic [31:0] fw(input int sl, input int md, input int v);
    return {16'h0000, sl[2:0], 3'h0, md[1:0], 1'b0, v[6:0]};
  endfunction : fw

  // Timeslot where a down sequence acts for the current sleep code
  function int tgt_of(input int c);
    return (c == 0) ? 5 : (c == 6) ? 3 : (c == 7) ? 1 : 6 - c;
  endfunction : tgt_of

  task tick(input int n, input bit dn);
    @(posedge pclk);
    slot_tick <= 1'b1;
    slot_num <= n[2:0];
    slot_down <= dn;
    @(posedge pclk);
    slot_tick <= 1'b0;
    if (!dn && n == a_sl && a_sl > 0 && a_sl < 6) st = 1;
    if (dn && st != 0 && n == tgt_of(s_sl))
      st = (a_sl >= 6 || s_sl == 0 || s_sl >= 6) ? 2 : 0;
  endtask : tick

  task hw(input bit e1, input bit e2);
    bit on;
    @(posedge pclk);
    hw_enable1 <= e1;
    hw_enable2 <= e2;
    on = (a_sl == 6) ? e1 : e2;
    st = on ? ((st == 2) ? 2 : 1) : 0;
  endtask : hw

  // Model drive and status word, then compare both
  task check_all;
    int v;
    repeat (3) @(posedge pclk);
    v = (st == 2 || (a_sl >= 6 && hsel != 0)) ? s_v : a_v;
    exp.enable = (st != 0);
    exp.mode = (st == 2) ? s_md[1:0] : a_md[1:0];
    exp.vcode = v[6:0];
    exp.mv = 12'(850 + 25 * ((v > 32'h0000_0066) ? 32'h0000_0066 : v));
    chk_drv(exp);
    apb(1'b0, b4sc_pkg::ADR_HWCTL, 32'h0);
    chk(rd, 32'(hsel * 1024 + (st != 0) * 4 + st));
  endtask : check_all

  // Hang guard, far beyond the roughly 550 cycles the tests need
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    end_of_test;
  end

  // Main sequence
  initial begin
    seed = 32'h0a32;
    {presetn, psel, penable, pwrite, slot_tick, slot_down} = 6'h00;
    {hw_enable1, hw_enable2, boot_load} = 3'h0;
    paddr = 18'h00000;
    pwdata = 32'h0;
    slot_num = 3'h0;
    boot_vcode_hi = 5'h00;
    error_cnt = 0;
    comparisons = 0;
    {st, hsel, a_sl, a_v, s_sl, s_v} = {6{32'd0}};
    a_md = 1;
    s_md = 3;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, b4sc_pkg::ADR_ACTIVE, 32'h0);
    chk(rd, 32'h0000_0100);
    apb(1'b0, b4sc_pkg::ADR_SLEEP, 32'h0);
    chk(rd, 32'h0000_0300);
    check_all;
    // Only unassigned bits set; unmapped word next door
    apb(1'b1, b4sc_pkg::ADR_ACTIVE, 32'hFFFF_1C80);
    a_md = 0;
    apb(1'b0, b4sc_pkg::ADR_ACTIVE, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, b4sc_pkg::ADR_SLEEP + 18'h00004, 32'hFFFF_FFFF);
    apb(1'b0, b4sc_pkg::ADR_SLEEP + 18'h00004, 32'h0);
    chk({err, rd[30:0]}, 32'h8000_0000);
    // Every sleep code, every mode, saturation edges of the code
    for (sc = 0; sc < 8; sc++) begin
      a_sl = 1 + ($unsigned($random(seed)) % 5);
      a_md = sc % 4;
      s_md = 3 - a_md;
      s_sl = sc;
      t = $random(seed) & 32'h0000_007F;
      a_v = (sc == 0) ? 7'h65 : (sc == 1) ? 7'h66 : (sc == 2) ? 7'h7F : t;
      s_v = $random(seed) & 32'h0000_007F;
      apb(1'b1, b4sc_pkg::ADR_ACTIVE, fw(a_sl, a_md, a_v));
      apb(1'b1, b4sc_pkg::ADR_SLEEP, fw(s_sl, s_md, s_v));
      tick(a_sl % 5 + 1, 1'b0);
      check_all;
      tick(a_sl, 1'b0);
      check_all;
      tick(tgt_of(sc) % 5 + 1, 1'b1);
      tick(tgt_of(sc), 1'b1);
      check_all;
      tick(a_sl, 1'b0);
      check_all;
      apb(1'b1, b4sc_pkg::ADR_ACTIVE, fw(0, a_md, a_v));
      a_sl = 0;
      st = 0;
      check_all;
    end
    // Hardware enable inputs; disable code acts as sleep
    for (i = 6; i < 8; i++) begin
      a_sl = i;
      s_sl = 3;
      apb(1'b1, b4sc_pkg::ADR_ACTIVE, fw(a_sl, a_md, a_v));
      apb(1'b1, b4sc_pkg::ADR_SLEEP, fw(s_sl, s_md, s_v));
      hw(i == 7, i == 6);
      check_all;
      hw(1'b1, 1'b1);
      check_all;
      apb(1'b1, b4sc_pkg::ADR_HWCTL, 32'hFFFF_FFFF);
      hsel = 1;
      check_all;
      tick(3, 1'b1);
      check_all;
      apb(1'b1, b4sc_pkg::ADR_HWCTL, 32'h0);
      hsel = 0;
      hw(1'b0, 1'b0);
      check_all;
    end
    // Boot load of the coarse code clears the fine bits
    a_sl = 0;
    a_md = 2;
    apb(1'b1, b4sc_pkg::ADR_ACTIVE, fw(0, 2, 32'h0000_007F));
    t = $random(seed) & 32'h0000_001F;
    @(posedge pclk);
    boot_load <= 1'b1;
    boot_vcode_hi <= t[4:0];
    @(posedge pclk);
    boot_load <= 1'b0;
    apb(1'b0, b4sc_pkg::ADR_ACTIVE, 32'h0);
    a_v = t * 4;
    chk(rd, fw(0, 2, a_v));
    a_sl = 1;
    apb(1'b1, b4sc_pkg::ADR_ACTIVE, fw(1, 2, a_v));
    tick(1, 1'b0);
    check_all;
    end_of_test;
  end
endmodule : b4sc_bench
`default_nettype wire
